// ---- lts_host.sv ----
// Host model driving the register port of one link table
module lts_host (
    input  logic        sys_clk,
    output logic [3:0]  reg_addr,
    output logic [15:0] reg_wdata,
    output logic        reg_wr,
    output logic        reg_rd,
    input  logic [15:0] reg_rdata
);
    timeunit 1ns;
    timeprecision 1ns;
    // Idle bus at time zero
    initial begin
        reg_addr = 4'h0;
        reg_wdata = 16'h0000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end
    // One-cycle write; config and K are only written while the queue is idle
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask
    // One-cycle read; answer taken at the edge closing the answer cycle
    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        @(posedge sys_clk);
        d = reg_rdata;
    endtask
endmodule

// ---- lts_link_table.v ----
// Per-link table state manager: registers, variables and status bits
//
// Chosen here: the register offsets and the strobed register port.
`include "lts_regs.vh"
module lts_link_table (
    input  wire        sys_clk,
    input  wire        rst_n,
    input  wire [3:0]  reg_addr,
    input  wire [15:0] reg_wdata,
    input  wire        reg_wr,
    input  wire        reg_rd,
    output reg  [15:0] reg_rdata,
    input  wire        ev_all_sent,
    input  wire        ev_all_acked,
    input  wire        ev_more_frames,
    input  wire        ev_poll_pending,
    input  wire        ev_timer_recovery,
    input  wire        ev_link_reset,
    input  wire        ev_established,
    input  wire        ev_serviced,
    input  wire        ev_last_in_queue,
    input  wire        ev_frame_sent,
    input  wire        ev_ack_advance,
    input  wire        ev_frame_received,
    input  wire        ev_remote_busy,
    input  wire        ev_remote_clear,
    input  wire        ev_status_response,
    input  wire        is_command,
    output wire        cr_bit,
    output wire        may_send_numbered,
    output wire        accept_data_frames,
    output wire        protocol_enable,
    output wire [12:0] dlci,
    output wire        pointer_valid,
    output reg         seq_write_back_reg,
    output reg         management_error_report_reg,
    output reg  [5:0]  error_arg_reg
);
    // Table entries kept for the link
    reg  [15:0] config_reg;
    reg  [6:0]  window_k_reg;
    reg  [6:0]  ack_var_reg;
    reg  [6:0]  send_var_reg;
    reg  [6:0]  recv_var_reg;
    reg         final_table_flag_reg;
    reg         remote_check_reg;
    reg         remote_busy_reg;
    reg         local_busy_reg;
    reg  [3:0]  cmd_code_reg;
    reg         cmd_valid_reg;
    // Next values of the sequence variables
    reg  [6:0]  send_var_next;
    reg  [6:0]  recv_var_next;
    reg  [6:0]  ack_var_next;
    // State machine outputs, conditions and word images
    wire [3:0]  xmit_state;
    wire        illegal;
    wire        ev_cond_set;
    wire        ev_cond_clear;
    wire [6:0]  outstanding;
    wire [15:0] xmit_word;
    wire [15:0] link_word;
    wire [15:0] seq_word;
    // Decoded strobes and derived flags
    wire        wr_cmd;
    wire        wr_config;
    wire        wr_window_k;
    wire        cmd_rem_status;
    wire        cmd_set_lbusy;
    wire        cmd_clr_lbusy;
    wire        k_limit;
    wire        active_bit;
    wire        seq_changed;

    // Packs a 7-bit variable into the top seven bits of a word
    function [15:0] lts_top7;
        input [6:0] v;
        begin
            lts_top7 = {v, 9'h000};
        end
    endfunction

    // True when a strobe hits the given register index
    function lts_addr_hit;
        input       strobe;
        input [3:0] addr;
        input [3:0] index;
        begin
            lts_addr_hit = strobe && (addr == index);
        end
    endfunction

    // True when a command pulse carries the given code
    function lts_cmd_hit;
        input       valid;
        input [3:0] code;
        input [3:0] want;
        begin
            lts_cmd_hit = valid && (code == want);
        end
    endfunction

    // Register and command decode shared by several processes
    assign wr_cmd         = lts_addr_hit(reg_wr, reg_addr, `LTS_ADDR_CMD);
    assign wr_config      = lts_addr_hit(reg_wr, reg_addr, `LTS_ADDR_CONFIG);
    assign wr_window_k    = lts_addr_hit(reg_wr, reg_addr, `LTS_ADDR_WINDOW_K);
    assign cmd_rem_status = lts_cmd_hit(cmd_valid_reg, cmd_code_reg, `LTS_CMD_REM_STATUS);
    assign cmd_set_lbusy  = lts_cmd_hit(cmd_valid_reg, cmd_code_reg, `LTS_CMD_SET_LBUSY);
    assign cmd_clr_lbusy  = lts_cmd_hit(cmd_valid_reg, cmd_code_reg, `LTS_CMD_CLR_LBUSY);

    // Register writes: a command write becomes a one-cycle command pulse
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cmd_code_reg  <= `LTS_CMD_NONE;
            cmd_valid_reg <= 1'b0;
            config_reg    <= `LTS_RST_WORD;
            window_k_reg  <= 7'h00;
        end else begin
            cmd_valid_reg <= wr_cmd;
            if (wr_cmd)
                cmd_code_reg <= reg_wdata[3:0];
            if (wr_config)
                config_reg <= {1'b0, reg_wdata[14:0]};
            if (wr_window_k)
                window_k_reg <= reg_wdata[15:9];
        end
    end

    // Blocking conditions stop the queue; their end relinks it
    assign k_limit       = (outstanding >= window_k_reg);
    assign ev_cond_set   = ev_poll_pending || ev_timer_recovery || remote_busy_reg || remote_check_reg ||
                           k_limit;
    assign ev_cond_clear = !ev_cond_set;

    lts_xmit_fsm u_fsm (
        .sys_clk       (sys_clk),
        .rst_n         (rst_n),
        .cmd_code      (cmd_code_reg),
        .cmd_valid     (cmd_valid_reg),
        .ev_all_sent   (ev_all_sent),
        .ev_all_acked  (ev_all_acked),
        .ev_more_frames(ev_more_frames),
        .ev_cond_set   (ev_cond_set),
        .ev_cond_clear (ev_cond_clear),
        .ev_link_reset (ev_link_reset),
        .ev_serviced   (ev_serviced),
        .state_reg     (xmit_state),
        .illegal_reg   (illegal)
    );

    // Final-table flag tracks the queue position at service time
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n)
            final_table_flag_reg <= 1'b0;
        else if (ev_serviced)
            final_table_flag_reg <= ev_last_in_queue;
    end
    // Pointer is usable only while another table follows
    assign pointer_valid = !final_table_flag_reg;

    // Illegal commands report a zero argument and change nothing
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            management_error_report_reg <= 1'b0;
            error_arg_reg               <= `LTS_ERR_ILLEGAL;
        end else begin
            management_error_report_reg <= illegal;
            if (illegal)
                error_arg_reg <= `LTS_ERR_ILLEGAL;
        end
    end

    // Sequence variables, modulo 128, cleared at establishment
    always @* begin
        send_var_next = send_var_reg;
        recv_var_next = recv_var_reg;
        ack_var_next  = ack_var_reg;
        if (ev_established) begin
            send_var_next = 7'h00;
            recv_var_next = 7'h00;
            ack_var_next  = 7'h00;
        end else begin
            if (ev_frame_sent && may_send_numbered)
                send_var_next = send_var_reg + 7'h01;
            if (ev_frame_received && accept_data_frames)
                recv_var_next = recv_var_reg + 7'h01;
            if (ev_ack_advance && ack_var_reg != send_var_reg)
                ack_var_next = ack_var_reg + 7'h01;
        end
    end

    // The word is written back only when one of its variables moves
    assign seq_changed = (send_var_next != send_var_reg) || (recv_var_next != recv_var_reg);

    // Variables and write-back pulse when the word changed
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            send_var_reg       <= 7'h00;
            recv_var_reg       <= 7'h00;
            ack_var_reg        <= 7'h00;
            seq_write_back_reg <= 1'b0;
        end else begin
            send_var_reg       <= send_var_next;
            recv_var_reg       <= recv_var_next;
            ack_var_reg        <= ack_var_next;
            seq_write_back_reg <= seq_changed;
        end
    end

    // Remote-status-check: set by the command, cleared by the response
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n)
            remote_check_reg <= 1'b0;
        else if (cmd_rem_status)
            remote_check_reg <= 1'b1;
        else if (ev_status_response || ev_link_reset)
            remote_check_reg <= 1'b0;
    end

    // Remote-busy follows the peer; a set event wins over its clear
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n)
            remote_busy_reg <= 1'b0;
        else if (ev_remote_busy)
            remote_busy_reg <= 1'b1;
        else if (ev_remote_clear || ev_established)
            remote_busy_reg <= 1'b0;
    end

    // Local-busy: set and cleared only by host commands
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n)
            local_busy_reg <= 1'b0;
        else if (cmd_set_lbusy)
            local_busy_reg <= 1'b1;
        else if (cmd_clr_lbusy)
            local_busy_reg <= 1'b0;
    end

    // Window check and numbered-send gate
    assign outstanding        = send_var_reg - ack_var_reg;
    assign active_bit         = xmit_state[`LTS_TS_ACTIVE - 1];
    assign may_send_numbered  = (window_k_reg != 7'h00) && (outstanding < window_k_reg) &&
                                active_bit;
    // Configuration decode and receive gate
    assign accept_data_frames = !local_busy_reg;
    assign protocol_enable    = !config_reg[`LTS_CFG_NONPROTO];
    assign dlci               = config_reg[`LTS_CFG_DLCI_W-1:0];
    assign cr_bit             = config_reg[`LTS_CFG_ROLE] ? !is_command : is_command;

    // Word images as held in the table
    assign xmit_word = {11'h000, xmit_state, final_table_flag_reg};
    assign link_word = {2'b00, remote_check_reg, remote_busy_reg, local_busy_reg, 11'h000};
    assign seq_word  = {send_var_reg, 1'b0, recv_var_reg, 1'b0};

    // Read port: data one cycle after the strobe, zero elsewhere
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= `LTS_RST_WORD;
        end else if (reg_rd) begin
            if (reg_addr == `LTS_ADDR_XMIT_STAT)
                reg_rdata <= xmit_word;
            else if (reg_addr == `LTS_ADDR_CONFIG)
                reg_rdata <= config_reg;
            else if (reg_addr == `LTS_ADDR_WINDOW_K)
                reg_rdata <= lts_top7(window_k_reg);
            else if (reg_addr == `LTS_ADDR_ACK_VAR)
                reg_rdata <= lts_top7(ack_var_reg);
            else if (reg_addr == `LTS_ADDR_SEQ_VARS)
                reg_rdata <= seq_word;
            else if (reg_addr == `LTS_ADDR_LINK_STAT)
                reg_rdata <= link_word;
            else if (reg_addr == `LTS_ADDR_ERROR)
                reg_rdata <= {10'h000, error_arg_reg};
            else
                reg_rdata <= `LTS_RST_WORD;
        end else begin
            reg_rdata <= `LTS_RST_WORD;
        end
    end
endmodule

// ---- lts_link_table_asserts.sv ----
// Port-level checks for the link table state manager
`include "lts_regs.vh"
module lts_link_table_asserts (
    input logic        sys_clk,
    input logic        rst_n,
    input logic [3:0]  reg_addr,
    input logic [15:0] reg_wdata,
    input logic        reg_wr,
    input logic        is_command,
    input logic        ev_frame_sent,
    input logic        ev_frame_received,
    input logic        ev_established,
    input logic        cr_bit,
    input logic        may_send_numbered,
    input logic        accept_data_frames,
    input logic        protocol_enable,
    input logic [12:0] dlci,
    input logic        seq_write_back_reg,
    input logic        management_error_report_reg,
    input logic [5:0]  error_arg_reg
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    // Decoded writes and sequence-variable causes
    wire cfg_wr = reg_wr && reg_addr == `LTS_ADDR_CONFIG;
    wire cmd_wr = reg_wr && reg_addr == `LTS_ADDR_CMD;
    wire seq_ev = ev_frame_sent || ev_frame_received || ev_established;
    AST_DLCI: assert property (cfg_wr |=> dlci == $past(reg_wdata[12:0]))
        else $error("dlci wrong");
    AST_NPROT: assert property (cfg_wr |=> protocol_enable == !$past(reg_wdata[14]))
        else $error("protocol enable wrong");
    AST_CR: assert property (cfg_wr |=> cr_bit == (is_command ^ $past(reg_wdata[13])))
        else $error("cr bit wrong");
    AST_LBUSY: assert property (cmd_wr && reg_wdata == 16'h000A |-> ##[1:3] !accept_data_frames)
        else $error("local busy not taken");
    AST_LCLR: assert property (cmd_wr && reg_wdata == 16'h000B |-> ##[1:3] accept_data_frames)
        else $error("local busy not cleared");
    AST_KZERO: assert property (reg_wr && reg_addr == `LTS_ADDR_WINDOW_K && reg_wdata[15:9] == 7'h00
        |=> !may_send_numbered [*8])
        else $error("numbered frame allowed with zero window");
    AST_ERRARG: assert property (management_error_report_reg |-> error_arg_reg == 6'h00
        ##1 !management_error_report_reg)
        else $error("error report wrong");
    AST_ERRSRC: assert property (management_error_report_reg |-> $past(cmd_wr, 3))
        else $error("error report without command");
    AST_WB: assert property (seq_write_back_reg |-> $past(seq_ev) || $past(seq_ev, 2))
        else $error("write back without change");
    // Main scenarios reached
    CV_ERR: cover property (management_error_report_reg);
    CV_WB: cover property (seq_write_back_reg);
    CV_SEND: cover property (may_send_numbered);
endmodule

// ---- lts_link_table_bench.sv ----
// Self-checking bench for the link table state manager
`include "lts_regs.vh"
module lts_link_table_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic        sys_clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [3:0]  reg_addr;
    logic [15:0] reg_wdata;
    logic        reg_wr;
    logic        reg_rd;
    logic [10:0] evp = 11'h000;
    logic [2:0]  lv = 3'h0;
    logic        last_q = 1'b0;
    logic        is_command = 1'b0;
    wire  [15:0] reg_rdata;
    wire  [12:0] dlci;
    wire  [5:0]  error_arg_reg;
    wire         cr_bit, may_send_numbered, accept_data_frames, protocol_enable, pointer_valid;
    wire         seq_write_back_reg, management_error_report_reg;
    int          n_errors = 0;
    int          samples_checked = 0;
    localparam logic [3:0] EST = 0, EAK = 1, ELR = 2, EES = 3, ESV = 4, EFS = 5, EAA = 6, EFR = 7, ENO = 15;
    // Event pulses and condition levels
    wire ev_all_sent = evp[0], ev_all_acked = evp[1], ev_link_reset = evp[2], ev_established = evp[3];
    wire ev_serviced = evp[4], ev_frame_sent = evp[5], ev_ack_advance = evp[6], ev_frame_received = evp[7];
    wire ev_remote_busy = evp[8], ev_remote_clear = evp[9], ev_status_response = evp[10];
    wire ev_more_frames = lv[0], ev_poll_pending = lv[1], ev_timer_recovery = lv[2], ev_last_in_queue = last_q;
    lts_link_table dut (
        .sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ev_all_sent(ev_all_sent), .ev_all_acked(ev_all_acked),
        .ev_more_frames(ev_more_frames), .ev_poll_pending(ev_poll_pending), .ev_timer_recovery(ev_timer_recovery),
        .ev_link_reset(ev_link_reset), .ev_established(ev_established), .ev_serviced(ev_serviced),
        .ev_last_in_queue(ev_last_in_queue), .ev_frame_sent(ev_frame_sent), .ev_ack_advance(ev_ack_advance),
        .ev_frame_received(ev_frame_received), .ev_remote_busy(ev_remote_busy), .ev_remote_clear(ev_remote_clear),
        .ev_status_response(ev_status_response), .is_command(is_command), .cr_bit(cr_bit),
        .may_send_numbered(may_send_numbered), .accept_data_frames(accept_data_frames),
        .protocol_enable(protocol_enable), .dlci(dlci), .pointer_valid(pointer_valid),
        .seq_write_back_reg(seq_write_back_reg), .management_error_report_reg(management_error_report_reg),
        .error_arg_reg(error_arg_reg)
    );
    lts_host host (
        .sys_clk(sys_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata)
    );
    always #50 sys_clk = ~sys_clk;
    // Compare a word against its expected value
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        samples_checked++;
        if (g !== e) begin
            n_errors++;
            $display("[ERR] %0t got %h expected %h", $time, g, e);
        end
    endtask
    task automatic rchk(input logic [3:0] a, input logic [15:0] e);
        logic [15:0] d;
        host.rd(a, d);
        chk(d, e);
    endtask
    task automatic pulse(input logic [3:0] b);
        @(posedge sys_clk);
        evp <= 11'h001 << b;
        @(posedge sys_clk);
        evp <= 11'h000;
    endtask
    // One command or event, then the state and error report are judged
    task automatic st(input logic k, input logic [3:0] c, input logic [3:0] s, input logic ill, input logic [2:0] l);
        int n;
        n = 0;
        lv <= l;
        if (k) host.wr(`LTS_ADDR_CMD, {12'h000, c});
        else pulse(c);
        repeat (3) begin
            @(negedge sys_clk);
            n += (management_error_report_reg === 1'b1);
        end
        rchk(`LTS_ADDR_XMIT_STAT, {11'h000, s, 1'b0});
        chk({15'h0000, n == 1}, {15'h0000, ill});
    endtask
    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // Hang guard
    initial begin
        repeat (20000) @(posedge sys_clk);
        n_errors++;
        end_sim;
    end
    // Main sequence
    initial begin
        repeat (10) @(posedge sys_clk);
        rst_n <= 1'b1;
        host.wr(`LTS_ADDR_LINK_STAT, 16'h0000);
        host.wr(`LTS_ADDR_XMIT_STAT, 16'hFFFF);
        for (int i = 0; i < 16; i++) begin
            rchk(i[3:0], 16'h0000);
        end
        chk({15'h0000, pointer_valid}, 16'h0001);
        host.wr(`LTS_ADDR_CONFIG, 16'hE123);
        is_command <= 1'b1;
        rchk(`LTS_ADDR_CONFIG, 16'h6123);
        chk({3'h0, dlci}, 16'h0123);
        chk({14'h0000, protocol_enable, cr_bit}, 16'h0000);
        host.wr(`LTS_ADDR_CONFIG, 16'h0ABC);
        rchk(`LTS_ADDR_CONFIG, 16'h0ABC);
        chk({14'h0000, protocol_enable, cr_bit}, 16'h0003);
        host.wr(`LTS_ADDR_WINDOW_K, 16'h0600);
        st(1, `LTS_CMD_RELINK, `LTS_S0, 1, 0);
        st(1, `LTS_CMD_ESTABLISH, `LTS_S8, 0, 0);
        st(1, `LTS_CMD_STOP_TX, `LTS_S8, 1, 0);
        st(1, `LTS_CMD_DATA_REQ, `LTS_S7, 0, 0);
        st(1, `LTS_CMD_DATA_REQ, `LTS_S7, 1, 0);
        st(1, `LTS_CMD_STOP_TX, `LTS_SE, 0, 0);
        st(0, ESV, `LTS_SA, 0, 0);
        st(0, EAK, `LTS_S8, 0, 0);
        st(1, `LTS_CMD_DATA_REQ, `LTS_S7, 0, 0);
        st(0, EST, `LTS_S2, 0, 0);
        st(1, `LTS_CMD_RELINK, `LTS_S7, 0, 0);
        st(0, ENO, `LTS_S3, 0, 2);
        st(1, `LTS_CMD_RELINK, `LTS_S3, 0, 2);
        st(1, `LTS_CMD_STOP_TX, `LTS_SA, 0, 2);
        st(1, `LTS_CMD_RELEASE, `LTS_S8, 0, 0);
        st(1, `LTS_CMD_DATA_REQ, `LTS_S7, 0, 0);
        st(0, ENO, `LTS_S3, 0, 4);
        st(0, ENO, `LTS_S7, 0, 0);
        st(0, EST, `LTS_S2, 0, 1);
        st(0, EAK, `LTS_S7, 0, 1);
        st(0, EST, `LTS_S2, 0, 0);
        st(0, EAK, `LTS_S0, 0, 0);
        st(1, `LTS_CMD_DATA_REQ, `LTS_S7, 0, 0);
        st(1, `LTS_CMD_DEACTIVATE, `LTS_SC, 0, 0);
        st(1, `LTS_CMD_DATA_REQ, `LTS_S7, 0, 0);
        st(1, `LTS_CMD_REMOVE, `LTS_SC, 0, 0);
        st(0, ESV, `LTS_S8, 0, 0);
        st(0, ELR, `LTS_S0, 0, 0);
        last_q <= 1'b1;
        pulse(ESV);
        rchk(`LTS_ADDR_XMIT_STAT, 16'h0001);
        chk({15'h0000, pointer_valid}, 16'h0000);
        last_q <= 1'b0;
        pulse(ESV);
        @(negedge sys_clk);
        chk({15'h0000, pointer_valid}, 16'h0001);
        host.wr(`LTS_ADDR_WINDOW_K, 16'h0400);
        host.wr(`LTS_ADDR_CMD, {12'h000, `LTS_CMD_DATA_REQ});
        pulse(EFS);
        @(negedge sys_clk);
        chk({15'h0000, may_send_numbered}, 16'h0001);
        pulse(EFS);
        rchk(`LTS_ADDR_SEQ_VARS, 16'h0400);
        chk({15'h0000, may_send_numbered}, 16'h0000);
        pulse(EAA);
        @(negedge sys_clk);
        chk({15'h0000, seq_write_back_reg}, 16'h0000);
        rchk(`LTS_ADDR_ACK_VAR, 16'h0200);
        chk({15'h0000, may_send_numbered}, 16'h0001);
        pulse(EFR);
        @(negedge sys_clk);
        chk({15'h0000, seq_write_back_reg}, 16'h0001);
        rchk(`LTS_ADDR_SEQ_VARS, 16'h0402);
        pulse(EES);
        rchk(`LTS_ADDR_ACK_VAR, 16'h0000);
        rchk(`LTS_ADDR_SEQ_VARS, 16'h0000);
        pulse(ELR);
        host.wr(`LTS_ADDR_WINDOW_K, 16'h0000);
        host.wr(`LTS_ADDR_CMD, {12'h000, `LTS_CMD_DATA_REQ});
        repeat (3) @(negedge sys_clk);
        chk({15'h0000, may_send_numbered}, 16'h0000);
        pulse(ELR);
        pulse(8);
        rchk(`LTS_ADDR_LINK_STAT, 16'h1000);
        pulse(9);
        rchk(`LTS_ADDR_LINK_STAT, 16'h0000);
        host.wr(`LTS_ADDR_CMD, {12'h000, `LTS_CMD_REM_STATUS});
        rchk(`LTS_ADDR_LINK_STAT, 16'h2000);
        pulse(10);
        rchk(`LTS_ADDR_LINK_STAT, 16'h0000);
        host.wr(`LTS_ADDR_CMD, {12'h000, `LTS_CMD_SET_LBUSY});
        rchk(`LTS_ADDR_LINK_STAT, 16'h0800);
        chk({15'h0000, accept_data_frames}, 16'h0000);
        host.wr(`LTS_ADDR_CMD, {12'h000, `LTS_CMD_CLR_LBUSY});
        rchk(`LTS_ADDR_LINK_STAT, 16'h0000);
        end_sim;
    end
endmodule
bind lts_link_table lts_link_table_asserts u_chk (
    .sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .is_command(is_command), .ev_frame_sent(ev_frame_sent), .ev_frame_received(ev_frame_received),
    .ev_established(ev_established), .cr_bit(cr_bit), .may_send_numbered(may_send_numbered),
    .accept_data_frames(accept_data_frames), .protocol_enable(protocol_enable), .dlci(dlci),
    .seq_write_back_reg(seq_write_back_reg), .management_error_report_reg(management_error_report_reg),
    .error_arg_reg(error_arg_reg)
);

// ---- lts_regs.vh ----
// Word layouts, state codes, command codes and register offsets for the link table state manager
`ifndef LTS_REGS_VH
`define LTS_REGS_VH
// Register offsets on the plain register port
`define LTS_ADDR_CMD        4'h0
`define LTS_ADDR_XMIT_STAT  4'h1
`define LTS_ADDR_CONFIG     4'h2
`define LTS_ADDR_WINDOW_K   4'h3
`define LTS_ADDR_ACK_VAR    4'h4
`define LTS_ADDR_SEQ_VARS   4'h5
`define LTS_ADDR_LINK_STAT  4'h6
`define LTS_ADDR_ERROR      4'h7
`define LTS_ADDR_EVENT      4'h8
// Transmit-status bit positions
`define LTS_TS_FINAL        0
`define LTS_TS_XMIT         1
`define LTS_TS_ACK          2
`define LTS_TS_ACTIVE       3
`define LTS_TS_HALT         4
// Transmit-status state codes: halt, active, acknowledge, transmit
`define LTS_S0              4'h0
`define LTS_S2              4'h2
`define LTS_S3              4'h3
`define LTS_S7              4'h7
`define LTS_S8              4'h8
`define LTS_SA              4'hA
`define LTS_SC              4'hC
`define LTS_SE              4'hE
// Command codes written to the command register
`define LTS_CMD_NONE        4'h0
`define LTS_CMD_DATA_REQ    4'h1
`define LTS_CMD_RELINK      4'h2
`define LTS_CMD_STOP_TX     4'h3
`define LTS_CMD_REMOVE      4'h4
`define LTS_CMD_RELEASE     4'h5
`define LTS_CMD_DEACTIVATE  4'h6
`define LTS_CMD_ESTABLISH   4'h7
`define LTS_CMD_ACTIVATE    4'h8
`define LTS_CMD_REM_STATUS  4'h9
`define LTS_CMD_SET_LBUSY   4'hA
`define LTS_CMD_CLR_LBUSY   4'hB
// Configuration word fields
`define LTS_CFG_DLCI_W      13
`define LTS_CFG_ROLE        13
`define LTS_CFG_NONPROTO    14
// Link-status bit positions
`define LTS_LS_LBUSY        11
`define LTS_LS_RBUSY        12
`define LTS_LS_RSCHK        13
// Error argument for an illegal command
`define LTS_ERR_ILLEGAL     6'h00
// Reset values
`define LTS_RST_WORD        16'h0000
`endif

// ---- lts_xmit_fsm.v ----
// Transmit-status state machine of one link table
`include "lts_regs.vh"
module lts_xmit_fsm (
    input  wire       sys_clk,
    input  wire       rst_n,
    input  wire [3:0] cmd_code,
    input  wire       cmd_valid,
    input  wire       ev_all_sent,
    input  wire       ev_all_acked,
    input  wire       ev_more_frames,
    input  wire       ev_cond_set,
    input  wire       ev_cond_clear,
    input  wire       ev_link_reset,
    input  wire       ev_serviced,
    output reg  [3:0] state_reg,
    output reg        illegal_reg
);
    reg [3:0] state_next;
    reg       illegal_next;

    // Next state from link reset first, then commands, then the other link events
    always @* begin
        state_next   = state_reg;
        illegal_next = 1'b0;
        if (ev_link_reset) begin
            state_next = `LTS_S0;
        end else if (cmd_valid && cmd_code == `LTS_CMD_DATA_REQ) begin
            if (state_reg == `LTS_S0 || state_reg == `LTS_S8 || state_reg == `LTS_SC)
                state_next = `LTS_S7;
            else
                illegal_next = 1'b1;
        end else if (cmd_valid && cmd_code == `LTS_CMD_STOP_TX) begin
            if (state_reg == `LTS_S3)
                state_next = `LTS_SA;
            else if (state_reg == `LTS_S7)
                state_next = `LTS_SE;
            else
                illegal_next = 1'b1;
        end else if (cmd_valid && (cmd_code == `LTS_CMD_REMOVE || cmd_code == `LTS_CMD_RELEASE ||
                                   cmd_code == `LTS_CMD_DEACTIVATE || cmd_code == `LTS_CMD_ESTABLISH)) begin
            if (state_reg == `LTS_S7 || state_reg == `LTS_SC || state_reg == `LTS_SE)
                state_next = `LTS_SC;
            else
                state_next = `LTS_S8;
        end else if (cmd_valid && cmd_code == `LTS_CMD_RELINK) begin
            if (state_reg == `LTS_S2)
                state_next = `LTS_S7;
            else if (state_reg != `LTS_S3 && state_reg != `LTS_S7)
                illegal_next = 1'b1;
        end else begin
            case (state_reg)
                `LTS_S7: begin
                    if (ev_cond_set)
                        state_next = `LTS_S3;
                    else if (ev_all_sent)
                        state_next = `LTS_S2;
                end
                `LTS_S3: begin
                    if (ev_cond_clear && !ev_cond_set)
                        state_next = `LTS_S7;
                end
                `LTS_S2: begin
                    if (ev_all_acked)
                        state_next = ev_more_frames ? `LTS_S7 : `LTS_S0;
                end
                `LTS_SA, `LTS_SE: begin
                    if (ev_all_acked)
                        state_next = `LTS_S8;
                    else if (ev_serviced && state_reg == `LTS_SE)
                        state_next = `LTS_SA;
                end
                `LTS_SC: begin
                    if (ev_serviced)
                        state_next = `LTS_S8;
                end
                default: state_next = state_reg;
            endcase
        end
    end

    // State and one-cycle illegal flag
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg   <= `LTS_S0;
            illegal_reg <= 1'b0;
        end else begin
            state_reg   <= state_next;
            illegal_reg <= illegal_next;
        end
    end
endmodule
